// File: hdl/sbr_defs.svh
/*
  constants for the system bus request block: command fields, lane codes,
  sizes and timing counts. assumes inclusion by bare name from both ends.
*/
`ifndef SBR_DEFS_SVH
`define SBR_DEFS_SVH
// ----------------------------------------------------------------------------
// command fields
// ----------------------------------------------------------------------------
`define SBR_CMD_W 9
`define SBR_CMD_ID_BIT 8
`define SBR_CMD_TYPE_HI 7
`define SBR_CMD_TYPE_LO 5
`define SBR_TYPE_READ 3'h0
`define SBR_TYPE_WRITE 3'h2
`define SBR_TYPE_NULL 3'h3
`define SBR_ATTR_HI 4
`define SBR_ATTR_LO 3
`define SBR_ATTR_BLOCK 2'h2
`define SBR_ATTR_WORD 2'h3
`define SBR_SIZE_HI 1
`define SBR_SIZE_LO 0
`define SBR_SZ_BYTE 2'h0
`define SBR_SZ_HALF 2'h1
`define SBR_SZ_TRI 2'h2
`define SBR_SZ_WORD 2'h3
`define SBR_BLK_2W 2'h0
`define SBR_BLK_8W 2'h1
`define SBR_ID_LAST_BIT 7
`define SBR_ID_RESP_BIT 6
`define SBR_ID_ERR_BIT 5
// ----------------------------------------------------------------------------
// address fields
// ----------------------------------------------------------------------------
`define SBR_RES_HI 6
`define SBR_RES_LO 4
`define SBR_RES_INTR 3'h0
`define SBR_DW_MASK 32'hFFFF_FFF8
`define SBR_W_MASK 32'hFFFF_FFFC
`define SBR_H_MASK 32'hFFFF_FFFE
`define SBR_BLK_MASK 32'hFFFF_FFE0
`define SBR_BLK_OFF_HI 4
`define SBR_BLK_WORDS 4'h8
`define SBR_OK_NEED 2'h2
`define SBR_INTR_W 8
`define SBR_INTR_RST 8'h00
`endif

// File: hdl/sbr_pkg.sv
/*
  types shared by both ends of the system bus request block.
  assumes sbr_defs.svh is on the include path.
*/
package sbr_pkg;
  typedef enum logic [2:0] {
    SBR_IDLE = 3'b000,
    SBR_ADDR = 3'b001,
    SBR_WDATA = 3'b010,
    SBR_RWAIT = 3'b011,
    SBR_EXT_RD = 3'b100
  } sbr_cpu_state_e;
  typedef enum logic [1:0] {
    SBR_A_IDLE = 2'b00,
    SBR_A_WRD = 2'b01,
    SBR_A_RESP = 2'b10
  } sbr_agt_state_e;
endpackage

// File: hdl/sbr_bus_if.sv
/*
  shared system bus between processor end and external agent end.
  resolves the address/data and command wires here from the processor end's enables.
*/
`timescale 1ns/10ps
`include "sbr_defs.svh"
interface sbr_bus_if;
  logic [31:0] cpu_ad;
  logic cpu_ad_oe;
  logic [`SBR_CMD_W-1:0] cpu_cmd;
  logic cpu_cmd_oe;
  logic cpu_valid;
  logic [31:0] agt_ad;
  logic agt_ad_oe;
  logic [`SBR_CMD_W-1:0] agt_cmd;
  logic agt_cmd_oe;
  logic agt_valid;
  logic agent_accept_ok_n;
  // resolved bus levels
  wire [31:0] sys_addr_data_bus = cpu_ad_oe ? cpu_ad : agt_ad;
  wire [`SBR_CMD_W-1:0] sys_command_bus = cpu_cmd_oe ? cpu_cmd : agt_cmd;
  modport cpu (output cpu_ad, cpu_ad_oe, cpu_cmd, cpu_cmd_oe, cpu_valid,
               input agt_ad, agt_cmd, agt_valid, agent_accept_ok_n);
  modport agent (output agt_ad, agt_ad_oe, agt_cmd, agt_cmd_oe, agt_valid,
                 agent_accept_ok_n, input cpu_ad, cpu_cmd, cpu_valid);
endinterface // sbr_bus_if

// File: hdl/sbr_cpu.sv
/*
  processor end: issues read and write requests, takes read responses and
  external write/read requests. assumes agent keeps request/response order.
*/
`timescale 1ns/10ps
`include "sbr_defs.svh"
module sbr_cpu (
  input wire logic mclk_i,
  input wire logic rst_i,
  sbr_bus_if.cpu bus,
  input wire logic compat_mode_select_n_i,
  input wire logic req_i,
  input wire logic req_write_i,
  input wire logic req_block_i,
  input wire logic [1:0] req_size_i,
  input wire logic [31:0] req_addr_i,
  input wire logic [31:0] req_wdata_i,
  input wire logic big_endian_i,
  output logic req_busy_o,
  output logic rd_data_valid_o,
  output logic [31:0] rd_data_o,
  output logic rd_done_o,
  output logic wr_done_o,
  output logic bus_error_o,
  output logic compat_mode_o,
  output logic [`SBR_INTR_W-1:0] intr_reg_o
);
  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic ok_s1_ff, ok_s2_ff, valid_s1_ff, valid_s2_ff;
  logic [31:0] ad_s1_ff, ad_s2_ff;
  logic [`SBR_CMD_W-1:0] cmd_s1_ff, cmd_s2_ff;
  logic sel_s1_ff, sel_s2_ff;
  // every pin input passes two flops; accept-ok sampled each edge
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ok_s1_ff <= 1'b1;
      ok_s2_ff <= 1'b1;
      valid_s1_ff <= 1'b0;
      valid_s2_ff <= 1'b0;
      ad_s1_ff <= 32'h0000_0000;
      ad_s2_ff <= 32'h0000_0000;
      cmd_s1_ff <= '0;
      cmd_s2_ff <= '0;
    end else begin
      ok_s1_ff <= bus.agent_accept_ok_n;
      ok_s2_ff <= ok_s1_ff;
      valid_s1_ff <= bus.agt_valid;
      valid_s2_ff <= valid_s1_ff;
      ad_s1_ff <= bus.agt_ad;
      ad_s2_ff <= ad_s1_ff;
      cmd_s1_ff <= bus.agt_cmd;
      cmd_s2_ff <= cmd_s1_ff;
    end
  end
  // strap runs through reset too, so release sees the cold-reset level
  always_ff @(posedge mclk_i) begin
    sel_s1_ff <= compat_mode_select_n_i;
    sel_s2_ff <= sel_s1_ff;
  end

  // ----------------------------------------------------------------------
  // accept-ok counting and mode latch
  // ----------------------------------------------------------------------
  logic [1:0] ok_cnt_ff, nxt_ok_cnt;
  logic mode_taken_ff;
  wire ok_ready = (ok_cnt_ff == `SBR_OK_NEED);
  // saturating count of consecutive low accept-ok cycles
  assign nxt_ok_cnt = ok_s2_ff ? 2'h0 : (ok_ready ? ok_cnt_ff : ok_cnt_ff + 2'h1);
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ok_cnt_ff <= 2'h0;
      mode_taken_ff <= 1'b0;
      compat_mode_o <= 1'b0;
    end else begin
      ok_cnt_ff <= nxt_ok_cnt;
      // choice caught once after release, held until next reset
      if (!mode_taken_ff) begin
        mode_taken_ff <= 1'b1;
        compat_mode_o <= ~sel_s2_ff;
      end
    end
  end

  // ----------------------------------------------------------------------
  // decode of incoming agent traffic
  // ----------------------------------------------------------------------
  wire in_id = cmd_s2_ff[`SBR_CMD_ID_BIT];
  wire [2:0] in_type = cmd_s2_ff[`SBR_CMD_TYPE_HI:`SBR_CMD_TYPE_LO];
  wire [2:0] in_res = ad_s2_ff[`SBR_RES_HI:`SBR_RES_LO];
  wire in_last = ~cmd_s2_ff[`SBR_ID_LAST_BIT];
  wire in_err = cmd_s2_ff[`SBR_ID_ERR_BIT];
  wire in_resp = valid_s2_ff & in_id & ~cmd_s2_ff[`SBR_ID_RESP_BIT];
  wire ext_wr_addr = valid_s2_ff & ~in_id & (in_type == `SBR_TYPE_WRITE);
  wire ext_rd_addr = valid_s2_ff & ~in_id & (in_type == `SBR_TYPE_READ);
  wire ext_wr_data = valid_s2_ff & in_id & cmd_s2_ff[`SBR_ID_RESP_BIT];
  // target kept from the address cycle; the data cycle carries only data
  logic [2:0] ext_res_ff;
  wire intr_hit = ext_wr_data & (ext_res_ff == `SBR_RES_INTR);

  // ----------------------------------------------------------------------
  // request address alignment
  // ----------------------------------------------------------------------
  wire [31:0] addr_half = req_addr_i & `SBR_H_MASK;
  wire [31:0] addr_word = req_addr_i & `SBR_W_MASK;
  wire [31:0] addr_dw = req_addr_i & `SBR_DW_MASK;
  // block writes start at the block's first doubleword
  wire [31:0] addr_blk = req_write_i ? (req_addr_i & `SBR_BLK_MASK) : addr_dw;
  wire [31:0] addr_aligned = req_block_i ? addr_blk :
                             (req_size_i == `SBR_SZ_WORD) ? addr_word :
                             (req_size_i == `SBR_SZ_HALF) ? addr_half : req_addr_i;
  // block reads give the wanted doubleword; lanes below it are dropped
  wire [31:0] addr_out = (req_block_i & ~req_write_i) ? (req_addr_i & `SBR_DW_MASK) :
                         addr_aligned;
  // single element placed on lanes by offset and endianness
  wire [1:0] off = addr_aligned[1:0];
  wire [1:0] lane_sh = big_endian_i ? (2'h3 - off - req_size_i) : off;
  wire [31:0] wdata_lane = req_block_i ? req_wdata_i : (req_wdata_i << {lane_sh, 3'b000});
  wire [1:0] attr = req_block_i ? `SBR_ATTR_BLOCK : `SBR_ATTR_WORD;
  wire [1:0] size_f = req_block_i ? `SBR_BLK_8W : req_size_i;
  wire [2:0] rtype = req_write_i ? `SBR_TYPE_WRITE : `SBR_TYPE_READ;
  // noncoherent: no coherency attribute is ever encoded
  wire [`SBR_CMD_W-1:0] cmd_req = {1'b0, rtype, attr, 1'b0, size_f};
  // processor write data identifiers never flag errors; the external read reply does
  wire [`SBR_CMD_W-1:0] cmd_data_last = {1'b1, 1'b0, 1'b1, 6'h00};
  wire [`SBR_CMD_W-1:0] cmd_data_more = {1'b1, 1'b1, 1'b1, 6'h00};
  wire [`SBR_CMD_W-1:0] cmd_ext_rd = {1'b1, 1'b0, 1'b0, 1'b1, 5'h00};

  // ----------------------------------------------------------------------
  // request state machine
  // ----------------------------------------------------------------------
  sbr_pkg::sbr_cpu_state_e st_ff;
  logic [3:0] beat_ff;
  logic blk_ff;
  logic [31:0] wdata_ff;
  wire [3:0] beats = blk_ff ? `SBR_BLK_WORDS : 4'h1;
  // issue only when idle: no read pending and agent ready
  wire can_issue = (st_ff == sbr_pkg::SBR_IDLE) & req_i & ok_ready & ~ext_rd_addr;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= sbr_pkg::SBR_IDLE;
      beat_ff <= 4'h0;
      blk_ff <= 1'b0;
      wdata_ff <= 32'h0000_0000;
      bus.cpu_ad <= 32'h0000_0000;
      bus.cpu_ad_oe <= 1'b0;
      bus.cpu_cmd <= '0;
      bus.cpu_cmd_oe <= 1'b0;
      bus.cpu_valid <= 1'b0;
      req_busy_o <= 1'b0;
      rd_data_valid_o <= 1'b0;
      rd_data_o <= 32'h0000_0000;
      rd_done_o <= 1'b0;
      wr_done_o <= 1'b0;
      bus_error_o <= 1'b0;
      intr_reg_o <= `SBR_INTR_RST;
      ext_res_ff <= ~`SBR_RES_INTR;
    end else begin
      rd_data_valid_o <= 1'b0;
      rd_done_o <= 1'b0;
      wr_done_o <= 1'b0;
      bus_error_o <= 1'b0;
      bus.cpu_valid <= 1'b0;
      // interrupt register is the only externally writable resource
      if (ext_wr_addr) begin
        ext_res_ff <= in_res;
      end
      if (intr_hit) begin
        intr_reg_o <= ad_s2_ff[`SBR_INTR_W-1:0];
      end
      case (st_ff)
        sbr_pkg::SBR_IDLE: begin
          bus.cpu_ad_oe <= 1'b0;
          bus.cpu_cmd_oe <= 1'b0;
          req_busy_o <= 1'b0;
          if (ext_rd_addr) begin
            st_ff <= sbr_pkg::SBR_EXT_RD;
          end else if (can_issue) begin
            // address cycle uses the whole bus
            bus.cpu_ad <= addr_out;
            bus.cpu_cmd <= cmd_req;
            bus.cpu_ad_oe <= 1'b1;
            bus.cpu_cmd_oe <= 1'b1;
            bus.cpu_valid <= 1'b1;
            req_busy_o <= 1'b1;
            blk_ff <= req_block_i;
            wdata_ff <= wdata_lane;
            beat_ff <= 4'h0;
            st_ff <= req_write_i ? sbr_pkg::SBR_WDATA : sbr_pkg::SBR_RWAIT;
          end
        end
        sbr_pkg::SBR_WDATA: begin
          // write data follows the address, sequential beats
          bus.cpu_ad <= blk_ff ? (wdata_ff + {28'h000_0000, beat_ff}) : wdata_ff;
          bus.cpu_cmd <= (beat_ff + 4'h1 == beats) ? cmd_data_last : cmd_data_more;
          bus.cpu_valid <= 1'b1;
          beat_ff <= beat_ff + 4'h1;
          if (beat_ff + 4'h1 == beats) begin
            wr_done_o <= 1'b1;
            st_ff <= sbr_pkg::SBR_IDLE;
          end
        end
        sbr_pkg::SBR_RWAIT: begin
          bus.cpu_ad_oe <= 1'b0;
          bus.cpu_cmd_oe <= 1'b0;
          // external writes may arrive meanwhile and are served above
          if (in_resp) begin
            rd_data_valid_o <= 1'b1;
            rd_data_o <= ad_s2_ff;
            bus_error_o <= in_err;
            if (in_last) begin
              rd_done_o <= 1'b1;
              st_ff <= sbr_pkg::SBR_IDLE;
            end
          end
        end
        sbr_pkg::SBR_EXT_RD: begin
          // nothing readable: undefined data, erroneous identifier
          bus.cpu_ad <= 32'h0000_0000;
          bus.cpu_cmd <= cmd_ext_rd;
          bus.cpu_ad_oe <= 1'b1;
          bus.cpu_cmd_oe <= 1'b1;
          bus.cpu_valid <= 1'b1;
          st_ff <= sbr_pkg::SBR_IDLE;
        end
        default: st_ff <= sbr_pkg::SBR_IDLE;
      endcase
    end
  end
endmodule // sbr_cpu

// File: hdl/sbr_agent.sv
/*
  external agent end: throttles requests, answers reads in subblock order,
  issues external writes. assumes memory contents come from the user side.
*/
`timescale 1ns/10ps
`include "sbr_defs.svh"
module sbr_agent (
  input wire logic mclk_i,
  input wire logic rst_i,
  sbr_bus_if.agent bus,
  input wire logic accept_hold_i,
  input wire logic [31:0] mem_rdata_i,
  input wire logic resp_err_i,
  input wire logic ext_wr_i,
  input wire logic [31:0] ext_wr_addr_i,
  input wire logic [31:0] ext_wr_data_i,
  output logic req_valid_o,
  output logic req_write_o,
  output logic [31:0] req_addr_o,
  output logic [`SBR_CMD_W-1:0] req_cmd_o,
  output logic wdata_valid_o,
  output logic [31:0] wdata_o,
  output logic [31:0] mem_raddr_o
);
  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic v1_ff, v2_ff;
  logic [31:0] a1_ff, a2_ff;
  logic [`SBR_CMD_W-1:0] c1_ff, c2_ff;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      v1_ff <= 1'b0;
      v2_ff <= 1'b0;
      a1_ff <= 32'h0000_0000;
      a2_ff <= 32'h0000_0000;
      c1_ff <= '0;
      c2_ff <= '0;
    end else begin
      v1_ff <= bus.cpu_valid;
      v2_ff <= v1_ff;
      a1_ff <= bus.cpu_ad;
      a2_ff <= a1_ff;
      c1_ff <= bus.cpu_cmd;
      c2_ff <= c1_ff;
    end
  end

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  wire in_req = v2_ff & ~c2_ff[`SBR_CMD_ID_BIT];
  wire in_rd = in_req & (c2_ff[`SBR_CMD_TYPE_HI:`SBR_CMD_TYPE_LO] == `SBR_TYPE_READ);
  wire in_wr = in_req & (c2_ff[`SBR_CMD_TYPE_HI:`SBR_CMD_TYPE_LO] == `SBR_TYPE_WRITE);
  wire in_blk = c2_ff[`SBR_ATTR_HI:`SBR_ATTR_LO] == `SBR_ATTR_BLOCK;
  wire in_data = v2_ff & c2_ff[`SBR_CMD_ID_BIT];
  wire [`SBR_CMD_W-1:0] id_more = {1'b1, 1'b1, 1'b0, 1'b0, 5'h00};
  wire [`SBR_CMD_W-1:0] id_last = {1'b1, 1'b0, 1'b0, 1'b0, 5'h00};
  // response identifier flags erroneous data on request
  wire [`SBR_CMD_W-1:0] id_err = {8'h00, 1'b0} | ({{(`SBR_CMD_W-1){1'b0}}, resp_err_i}
                                  << `SBR_ID_ERR_BIT);
  // address passes as given: decode 000 picks the interrupt register
  wire [31:0] ext_addr = ext_wr_addr_i;
  wire [`SBR_CMD_W-1:0] ext_cmd = {1'b0, `SBR_TYPE_WRITE, `SBR_ATTR_WORD, 1'b0, `SBR_SZ_WORD};

  // ----------------------------------------------------------------------
  // agent state machine
  // ----------------------------------------------------------------------
  sbr_pkg::sbr_agt_state_e st_ff;
  logic [3:0] beat_ff, total_ff;
  logic [31:0] base_ff;
  wire last_beat = (beat_ff + 4'h1 == total_ff);
  // wrap inside the block starting at the addressed doubleword
  wire [`SBR_BLK_OFF_HI:0] sub_off = base_ff[`SBR_BLK_OFF_HI:0] + {beat_ff[2:0], 2'b00} + 5'h04;
  wire [31:0] sub_addr = {base_ff[31:`SBR_BLK_OFF_HI+1], sub_off};
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= sbr_pkg::SBR_A_IDLE;
      beat_ff <= 4'h0;
      total_ff <= 4'h0;
      base_ff <= 32'h0000_0000;
      bus.agt_ad <= 32'h0000_0000;
      bus.agt_ad_oe <= 1'b0;
      bus.agt_cmd <= '0;
      bus.agt_cmd_oe <= 1'b0;
      bus.agt_valid <= 1'b0;
      bus.agent_accept_ok_n <= 1'b1;
      req_valid_o <= 1'b0;
      req_write_o <= 1'b0;
      req_addr_o <= 32'h0000_0000;
      req_cmd_o <= '0;
      wdata_valid_o <= 1'b0;
      wdata_o <= 32'h0000_0000;
      mem_raddr_o <= 32'h0000_0000;
    end else begin
      req_valid_o <= in_req;
      req_write_o <= in_wr;
      req_addr_o <= a2_ff;
      req_cmd_o <= c2_ff;
      wdata_valid_o <= in_data;
      wdata_o <= a2_ff;
      bus.agt_valid <= 1'b0;
      // ready only when idle with no read arriving and user does not hold off
      bus.agent_accept_ok_n <= accept_hold_i | (st_ff != sbr_pkg::SBR_A_IDLE) | in_rd;
      case (st_ff)
        sbr_pkg::SBR_A_IDLE: begin
          bus.agt_ad_oe <= 1'b0;
          bus.agt_cmd_oe <= 1'b0;
          if (in_rd) begin
            base_ff <= a2_ff;
            mem_raddr_o <= a2_ff;
            beat_ff <= 4'h0;
            total_ff <= in_blk ? `SBR_BLK_WORDS : 4'h1;
            st_ff <= sbr_pkg::SBR_A_RESP;
          end else if (ext_wr_i && !in_req && !in_data) begin
            bus.agt_ad <= ext_addr;
            bus.agt_cmd <= ext_cmd;
            bus.agt_ad_oe <= 1'b1;
            bus.agt_cmd_oe <= 1'b1;
            bus.agt_valid <= 1'b1;
            st_ff <= sbr_pkg::SBR_A_WRD;
          end
        end
        sbr_pkg::SBR_A_WRD: begin
          bus.agt_ad <= ext_wr_data_i;
          bus.agt_cmd <= id_last | {2'b00, 1'b1, 6'h00};
          bus.agt_valid <= 1'b1;
          st_ff <= sbr_pkg::SBR_A_IDLE;
        end
        sbr_pkg::SBR_A_RESP: begin
          bus.agt_ad <= mem_rdata_i;
          bus.agt_cmd <= (last_beat ? id_last : id_more) | id_err;
          bus.agt_ad_oe <= 1'b1;
          bus.agt_cmd_oe <= 1'b1;
          bus.agt_valid <= 1'b1;
          beat_ff <= beat_ff + 4'h1;
          mem_raddr_o <= sub_addr;
          if (last_beat) begin
            st_ff <= sbr_pkg::SBR_A_IDLE;
          end
        end
        default: st_ff <= sbr_pkg::SBR_A_IDLE;
      endcase
    end
  end
endmodule // sbr_agent

// File: dv/sbr_chk.sv
/*
  bus checker between processor end and agent end.
  assumes the bench wires in the interface signals, clock and reset.
*/
`timescale 1ns/10ps
`include "sbr_defs.svh"
module sbr_chk (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [31:0] cpu_ad,
  input wire logic cpu_ad_oe,
  input wire logic [`SBR_CMD_W-1:0] cpu_cmd,
  input wire logic cpu_cmd_oe,
  input wire logic cpu_valid,
  input wire logic [`SBR_CMD_W-1:0] agt_cmd,
  input wire logic agt_valid,
  input wire logic agent_accept_ok_n
);
  // ------------------------------------------------------------
  // cycle decode
  // ------------------------------------------------------------
  wire c_req = cpu_valid && !cpu_cmd[`SBR_CMD_ID_BIT];
  wire c_dat = cpu_valid && cpu_cmd[`SBR_CMD_ID_BIT];
  wire [2:0] c_typ = cpu_cmd[`SBR_CMD_TYPE_HI:`SBR_CMD_TYPE_LO];
  wire c_blk = cpu_cmd[`SBR_ATTR_HI:`SBR_ATTR_LO] == `SBR_ATTR_BLOCK;
  wire [1:0] c_sz = cpu_cmd[`SBR_SIZE_HI:`SBR_SIZE_LO];
  wire c_word = c_req && !c_blk && c_sz == `SBR_SZ_WORD;
  wire c_half = c_req && !c_blk && c_sz == `SBR_SZ_HALF;
  wire rd_req = c_req && c_typ == `SBR_TYPE_READ;
  wire wr_req = c_req && c_typ == `SBR_TYPE_WRITE;
  wire a_dat = agt_valid && agt_cmd[`SBR_CMD_ID_BIT] && !agt_cmd[`SBR_ID_RESP_BIT];
  logic [5:0] ok_hist_ff;
  logic [3:0] beats_ff;
  // loose window: the processor end synchronises accept-ok first
  wire ok_pair = |(~(ok_hist_ff[4:0] | ok_hist_ff[5:1]));
  wire [3:0] nxt_beats = rd_req ? (c_blk ? `SBR_BLK_WORDS : 4'h1) :
    (a_dat && beats_ff != 4'h0) ? beats_ff - 4'h1 : beats_ff;
  // accept-ok history and response beats still owed
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ok_hist_ff <= 6'h3F;
      beats_ff <= 4'h0;
    end else begin
      ok_hist_ff <= {ok_hist_ff[4:0], agent_accept_ok_n};
      beats_ff <= nxt_beats;
    end
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking dcb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  a_addr_drive: assert property (c_req |-> cpu_ad_oe && cpu_cmd_oe)
    else $error("address cycle without bus drive");
  a_blk_align: assert property (c_req && c_blk |-> cpu_ad[2:0] == 3'h0)
    else $error("block address not doubleword aligned");
  a_word_align: assert property (c_word |-> cpu_ad[1:0] == 2'h0)
    else $error("word address not aligned");
  a_half_align: assert property (c_half |-> !cpu_ad[0])
    else $error("halfword address not aligned");
  a_cmd_legal: assert property (c_req |-> rd_req || wr_req)
    else $error("request type not read or write");
  a_read_alone: assert property (rd_req |=> !cpu_valid)
    else $error("read request followed by a processor cycle");
  a_write_data: assert property (wr_req |=> c_dat)
    else $error("write request without data cycle");
  a_blk_beats: assert property (wr_req && c_blk |=> c_dat [*8])
    else $error("block write beats not back to back");
  a_ok_gate: assert property (c_req |-> ok_pair)
    else $error("request without two accept-ok cycles");
  a_one_pend: assert property (c_req |-> beats_ff == 4'h0)
    else $error("request issued while read pending");
  c_blk_rd: cover property (rd_req && c_blk);
  c_blk_wr: cover property (wr_req && c_blk);
  c_err_resp: cover property (a_dat && agt_cmd[`SBR_ID_ERR_BIT]);
endmodule // sbr_chk

// File: dv/test_cpu_system_bus_request_addressing.sv
/*
  self-checking bench: both ends joined by the bus interface.
  assumes a 100 MHz clock and inputs driven at the falling edge.
*/
`timescale 1ns/10ps
`include "sbr_defs.svh"
module test_cpu_system_bus_request_addressing;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req = 1'b0, wr = 1'b0, blk = 1'b0, be = 1'b0;
  logic hold = 1'b0, rerr = 1'b0, ext = 1'b0, sel = 1'b0;
  logic [1:0] sz = 2'h0;
  logic [31:0] addr = 32'h0000_0000, wdat = 32'h0000_0000, mem_d = 32'h0000_0000;
  logic [31:0] ext_a = 32'h0000_0000, ext_d = 32'h0000_0000;
  logic busy, rdv, rdone, wdone, berr, cmode, a_rv, a_rw, a_wv;
  logic [31:0] rdat, a_ra, a_wd, a_mra, seen_a, ext_seen;
  logic [8:0] a_rc, seen_c;
  logic [7:0] intr;
  logic [31:0] wq[$];
  logic [31:0] rq[$];
  int n_req, n_err, n_done, cyc, miscompares, checks_done;
  sbr_bus_if sbr_bus_if_i ();
  sbr_cpu sbr_cpu_i (.mclk_i(mclk_i), .rst_i(rst_i), .bus(sbr_bus_if_i.cpu),
    .compat_mode_select_n_i(sel), .req_i(req), .req_write_i(wr), .req_block_i(blk),
    .req_size_i(sz), .req_addr_i(addr), .req_wdata_i(wdat), .big_endian_i(be),
    .req_busy_o(busy), .rd_data_valid_o(rdv), .rd_data_o(rdat), .rd_done_o(rdone),
    .wr_done_o(wdone), .bus_error_o(berr), .compat_mode_o(cmode), .intr_reg_o(intr));
  sbr_agent sbr_agent_i (.mclk_i(mclk_i), .rst_i(rst_i), .bus(sbr_bus_if_i.agent),
    .accept_hold_i(hold), .mem_rdata_i(mem_d), .resp_err_i(rerr), .ext_wr_i(ext),
    .ext_wr_addr_i(ext_a), .ext_wr_data_i(ext_d), .req_valid_o(a_rv), .req_write_o(a_rw),
    .req_addr_o(a_ra), .req_cmd_o(a_rc), .wdata_valid_o(a_wv), .wdata_o(a_wd),
    .mem_raddr_o(a_mra));
  sbr_chk sbr_chk_i (.mclk_i(mclk_i), .rst_i(rst_i), .cpu_ad(sbr_bus_if_i.cpu_ad),
    .cpu_ad_oe(sbr_bus_if_i.cpu_ad_oe), .cpu_cmd(sbr_bus_if_i.cpu_cmd),
    .cpu_cmd_oe(sbr_bus_if_i.cpu_cmd_oe), .cpu_valid(sbr_bus_if_i.cpu_valid),
    .agt_cmd(sbr_bus_if_i.agt_cmd), .agt_valid(sbr_bus_if_i.agt_valid),
    .agent_accept_ok_n(sbr_bus_if_i.agent_accept_ok_n));
  // ------------------------------------------------------------
  // clock, memory model, capture
  // ------------------------------------------------------------
  always #5 mclk_i = ~mclk_i;
  // memory word is its address with a marker, so order shows
  always @(negedge mclk_i) mem_d <= a_mra ^ 32'h5A5A_0000;
  // echoes last one cycle, so they are caught at every edge
  always @(posedge mclk_i) begin
    cyc++;
    if (a_rv) begin
      seen_a = a_ra;
      seen_c = a_rc;
      n_req++;
    end
    if (a_wv) wq.push_back(a_wd);
    if (rdv) rq.push_back(rdat);
    if (berr) n_err++;
    if (rdone || wdone) n_done++;
    if (sbr_bus_if_i.agt_valid && !sbr_bus_if_i.agt_cmd[`SBR_CMD_ID_BIT])
      ext_seen = sbr_bus_if_i.sys_addr_data_bus;
    if (cyc == 20000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // request held until busy shows; bounded in case it never does
  task automatic issue(input logic w, input logic b, input logic [1:0] s,
                       input logic [31:0] a, input logic [31:0] d);
    int k;
    @(negedge mclk_i);
    wq.delete();
    rq.delete();
    n_req = 0;
    n_err = 0;
    n_done = 0;
    wr = w;
    blk = b;
    sz = s;
    addr = a;
    wdat = d;
    req = 1'b1;
    k = 0;
    while (busy !== 1'b1 && k < 200) begin
      @(negedge mclk_i);
      k++;
    end
    req = 1'b0;
  endtask
  // wait for completion, then let the agent echoes land
  task automatic settle();
    int k;
    k = 0;
    while (n_done < 1 && k < 200) begin
      @(negedge mclk_i);
      k++;
    end
    repeat (8) @(negedge mclk_i);
  endtask
  task automatic ext_write(input logic [31:0] a, input logic [31:0] d);
    @(negedge mclk_i);
    ext_a = a;
    ext_d = d;
    ext = 1'b1;
    @(negedge mclk_i);
    ext = 1'b0;
    repeat (20) @(negedge mclk_i);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial begin
    int ln;
    logic [31:0] m;
    repeat (6) @(negedge mclk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge mclk_i);
    check("compat mode", 32'h0000_0001, cmode);
    issue(1'b1, 1'b0, `SBR_SZ_WORD, 32'h0000_1003, 32'hCAFE_0123);
    settle();
    check("word addr", 32'h0000_1000, seen_a);
    check("write type", `SBR_TYPE_WRITE, seen_c[7:5]);
    check("word data", 32'hCAFE_0123, wq[0]);
    check("word done", 32'h0000_0001, n_done);
    $display("test word write done");
    // every partial size, offset and byte order; halfwords given odd
    for (int e = 0; e < 2; e++) begin
      for (int s = 0; s < 3; s++) begin
        for (int o = 0; o + s < 4; o += (s == 1) ? 2 : 1) begin
          be = e[0];
          issue(1'b1, 1'b0, s[1:0], 32'h0000_1100 + o + (s == 1), 32'h00C3_B2A1);
          settle();
          ln = e ? 3 - s - o : o;
          m = ~(32'hFFFF_FFFF << (8 * (s + 1)));
          check("part addr", 32'h0000_1100 + o, seen_a);
          check("part lane", 32'h00C3_B2A1 & m, (wq[0] >> (8 * ln)) & m);
        end
      end
    end
    be = 1'b0;
    $display("test partial lanes done");
    issue(1'b1, 1'b1, `SBR_SZ_WORD, 32'h0000_2014, 32'h1111_0000);
    settle();
    check("blk wr addr", 32'h0000_2000, seen_a);
    check("blk wr beats", 32'h0000_0008, wq.size());
    for (int i = 0; i < 8; i++) check("blk wr data", 32'h1111_0000 + i, wq[i]);
    $display("test block write done");
    issue(1'b0, 1'b1, `SBR_SZ_WORD, 32'h0000_3014, 32'h0000_0000);
    settle();
    check("blk rd addr", 32'h0000_3010, seen_a);
    check("read type", `SBR_TYPE_READ, seen_c[7:5]);
    check("blk rd beats", 32'h0000_0008, rq.size());
    check("blk rd first", 32'h5A5A_3010, rq[0]);
    check("blk rd wrap", 32'h5A5A_300C, rq[7]);
    check("rd done", 32'h0000_0001, n_done);
    check("clean read", 32'h0000_0000, n_err);
    $display("test block read done");
    rerr = 1'b1;
    issue(1'b0, 1'b0, `SBR_SZ_WORD, 32'h0000_4000, 32'h0000_0000);
    // external write slips in ahead of the response: a split read
    ext_a = 32'h0000_0200;
    ext_d = 32'h0000_005A;
    ext = 1'b1;
    @(negedge mclk_i);
    ext = 1'b0;
    settle();
    rerr = 1'b0;
    check("bus error", 32'h0000_0001, n_err);
    check("split intr", 32'h0000_005A, intr);
    $display("test error read done");
    // accept-ok withheld for a while, then released
    hold = 1'b1;
    // let the held level pass the synchronisers before asking
    repeat (4) @(negedge mclk_i);
    fork
      begin
        repeat (20) @(negedge mclk_i);
        check("held no req", 32'h0000_0000, n_req);
        hold = 1'b0;
      end
    join_none
    issue(1'b1, 1'b0, `SBR_SZ_WORD, 32'h0000_5000, 32'h0000_5555);
    settle();
    check("req after ok", 32'h0000_0001, n_req);
    $display("test accept hold done");
    ext_write(32'h0000_0100, 32'h0000_00A5);
    check("intr sel 000", 32'h0000_00A5, intr);
    check("ext addr wire", 32'h0000_0100, ext_seen);
    ext_write(32'h0000_0010, 32'h0000_003C);
    check("intr sel 001", 32'h0000_00A5, intr);
    $display("test external write done");
    // cold reset again with the strap high: native mode
    sel = 1'b1;
    rst_i = 1'b1;
    repeat (6) @(negedge mclk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge mclk_i);
    check("native mode", 32'h0000_0000, cmode);
    $display("test strap reset done");
    complete_run();
  end
endmodule // test_cpu_system_bus_request_addressing
